//--- ptwd_defs.vh
// constants for the periodic timer and watchdog block
// assumes inclusion by bare name from design files
`ifndef PTWD_DEFS_VH
`define PTWD_DEFS_VH
`define PTWD_ADDR_CONFIG 4'h0
`define PTWD_ADDR_PRESCALER 4'h1
`define PTWD_ADDR_PRESET 4'h2
`define PTWD_ADDR_TCSR 4'h3
`define PTWD_ADDR_RELOAD 4'h4
`define PTWD_ADDR_SERVICE 4'h5
`define PTWD_ADDR_STATUS 4'h6
`define PTWD_TCSR_RESTART 0
`define PTWD_TCSR_TC 1
`define PTWD_TCSR_IRQEN 2
`define PTWD_CFG_LCFG 0
`define PTWD_CFG_LPRE 1
`define PTWD_CFG_LPRESET 2
`define PTWD_CFG_LRELOAD 3
`define PTWD_CFG_CLKSEL 4
`define PTWD_CFG_MATCHEN 5
`define PTWD_RELOAD_RST 8'h0F
`define PTWD_PRESET_RST 16'hFFFF
`define PTWD_SERVICE_KEY 8'h5C
`define PTWD_FILL_DATA 8'h00
`endif

//--- ptwd_sync.v
// two-flop level synchroniser for the slow clock input
// assumes clk and resetn of the main block
`timescale 1ns/1ps
`default_nettype none
module ptwd_sync (
  input wire clk,
  input wire resetn,
  input wire d,
  output reg q
);
  reg meta_reg;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // ptwd_sync
`default_nettype wire

//--- ptwd_timer_wdog.v
// periodic timer and watchdog with classic wishbone register slave
// assumes slow_clk at most a quarter of clk; wdog_error drives the system reset
// Functional notes
// - restart reloads timer on next tick, self-clears
// - writing zero to restart does nothing
// - terminal count set at zero, read clears
// - interrupt per zero when enabled
// - control byte: restart, tc, irq enable
// - reload count resets 0F, write starts/restarts
// - match key 5C reloads watchdog
// - wrong key with match enabled errors
// - two services in one tick error
// - match disabled ignores service writes
// - six prescaler rates; timer divides by preset+1
// - reload count bounds ticks between services
// - any watchdog error resets device
// - config bits sticky; locked registers ignore writes
// - timer reloads preset on underflow; FFFF
// - clock select one: prescaled, zero: timer output
`timescale 1ns/1ps
`default_nettype none
`include "ptwd_defs.vh"
module ptwd_timer_wdog #(
  parameter PRESET_W = 16
) (
  input wire clk,
  input wire resetn,
  input wire slow_clk,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:2] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg timer_irq,
  output reg periodic_timer_output,
  output reg wdog_error
);
  wire slow_sync;
  reg slow_prev_reg;
  reg [7:0] wdog_config_reg;
  reg [2:0] slow_prescaler_reg;
  reg [PRESET_W-1:0] periodic_preset_reg;
  reg [PRESET_W-1:0] timer_count_reg;
  reg restart_reg;
  reg terminal_count_flag;
  reg timer_irq_enable;
  reg [7:0] wdog_reload_count;
  reg [7:0] wdog_count_reg;
  reg wdog_running_reg;
  reg [4:0] prescale_cnt_reg;
  reg svc_pending_reg;
  reg reload_pending_reg;
  reg [7:0] reload_val_reg;
  wire rise_slow;
  wire presc_tick;
  wire timer_zero;
  wire wdog_tick;
  wire bus_req;
  wire wr_ok;
  wire rd_ok;
  wire lane0;
  reg [4:0] presc_div;

  ptwd_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .d(slow_clk),
    .q(slow_sync)
  );

  assign rise_slow = slow_sync & ~slow_prev_reg;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign lane0 = wb_sel_i[0];
  assign wr_ok = bus_req & wb_we_i;
  assign rd_ok = bus_req & ~wb_we_i;

  always @* begin
    case (slow_prescaler_reg)
      3'h0: presc_div = 5'h00;
      3'h1: presc_div = 5'h01;
      3'h2: presc_div = 5'h03;
      3'h3: presc_div = 5'h07;
      3'h4: presc_div = 5'h0F;
      3'h5: presc_div = 5'h1F;
      default: presc_div = 5'h00; // reserved codes run undivided
    endcase
  end

  // one tick per divided slow clock edge
  assign presc_tick = rise_slow && (prescale_cnt_reg == 5'h00);
  assign timer_zero = presc_tick && !restart_reg && (timer_count_reg == {PRESET_W{1'b0}});
  assign wdog_tick = wdog_config_reg[`PTWD_CFG_CLKSEL] ? presc_tick : timer_zero;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slow_prev_reg <= 1'b0;
      prescale_cnt_reg <= 5'h00;
    end else begin
      slow_prev_reg <= slow_sync;
      if (rise_slow) begin
        if (prescale_cnt_reg == 5'h00)
          prescale_cnt_reg <= presc_div;
        else
          prescale_cnt_reg <= prescale_cnt_reg - 5'h01;
      end
    end
  end

  // periodic timer
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_count_reg <= `PTWD_PRESET_RST;
      periodic_timer_output <= 1'b0;
    end else begin
      periodic_timer_output <= timer_zero;
      if (presc_tick) begin
        if (restart_reg)
          timer_count_reg <= periodic_preset_reg;
        else if (timer_count_reg == {PRESET_W{1'b0}})
          timer_count_reg <= periodic_preset_reg;
        else
          timer_count_reg <= timer_count_reg - {{(PRESET_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // register writes and control/status bits
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdog_config_reg <= 8'h00;
      slow_prescaler_reg <= 3'h0;
      periodic_preset_reg <= `PTWD_PRESET_RST;
      restart_reg <= 1'b0;
      terminal_count_flag <= 1'b0;
      timer_irq_enable <= 1'b0;
      wdog_reload_count <= `PTWD_RELOAD_RST;
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= timer_zero & timer_irq_enable;
      if (presc_tick && restart_reg)
        restart_reg <= 1'b0;
      // set wins over read clear
      if (timer_zero)
        terminal_count_flag <= 1'b1;
      else if (rd_ok && wb_adr_i == `PTWD_ADDR_TCSR && !wdog_config_reg[`PTWD_CFG_LPRESET])
        terminal_count_flag <= 1'b0;
      if (wr_ok && lane0) begin
        case (wb_adr_i)
          `PTWD_ADDR_CONFIG: begin
            if (!wdog_config_reg[`PTWD_CFG_LCFG])
              wdog_config_reg <= wdog_config_reg | {2'b00, wb_dat_i[5:0]};
          end
          `PTWD_ADDR_PRESCALER: begin
            if (!wdog_config_reg[`PTWD_CFG_LPRE])
              slow_prescaler_reg <= wb_dat_i[2:0];
          end
          `PTWD_ADDR_PRESET: begin
            if (!wdog_config_reg[`PTWD_CFG_LPRESET])
              periodic_preset_reg <= wb_dat_i[PRESET_W-1:0];
          end
          `PTWD_ADDR_TCSR: begin
            if (!wdog_config_reg[`PTWD_CFG_LPRESET]) begin
              timer_irq_enable <= wb_dat_i[`PTWD_TCSR_IRQEN];
              if (wb_dat_i[`PTWD_TCSR_RESTART])
                restart_reg <= 1'b1;
            end
          end
          `PTWD_ADDR_RELOAD: begin
            if (!wdog_config_reg[`PTWD_CFG_LRELOAD])
              wdog_reload_count <= wb_dat_i[7:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // watchdog: requests wait for the next tick
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdog_count_reg <= `PTWD_RELOAD_RST;
      wdog_running_reg <= 1'b0;
      svc_pending_reg <= 1'b0;
      reload_pending_reg <= 1'b0;
      reload_val_reg <= `PTWD_RELOAD_RST;
      wdog_error <= 1'b0;
    end else begin
      if (wr_ok && lane0 && wb_adr_i == `PTWD_ADDR_RELOAD
          && !wdog_config_reg[`PTWD_CFG_LRELOAD]) begin
        wdog_running_reg <= 1'b1;
        reload_pending_reg <= 1'b1;
        reload_val_reg <= wb_dat_i[7:0];
      end else if (wdog_tick)
        reload_pending_reg <= 1'b0;
      if (wr_ok && lane0 && wb_adr_i == `PTWD_ADDR_SERVICE
          && wdog_config_reg[`PTWD_CFG_MATCHEN]) begin
        wdog_running_reg <= 1'b1;
        if (wb_dat_i[7:0] != `PTWD_SERVICE_KEY)
          wdog_error <= 1'b1;
        else if (svc_pending_reg && !wdog_tick)
          wdog_error <= 1'b1;
        svc_pending_reg <= 1'b1;
      end else if (wdog_tick)
        svc_pending_reg <= 1'b0;
      if (wdog_running_reg && wdog_tick) begin
        if (reload_pending_reg)
          wdog_count_reg <= reload_val_reg;
        else if (svc_pending_reg)
          wdog_count_reg <= wdog_reload_count;
        else if (wdog_count_reg == 8'h00)
          wdog_error <= 1'b1;
        else
          wdog_count_reg <= wdog_count_reg - 8'h01;
      end
    end
  end

  // wishbone answer, one cycle after request
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h00000000;
      if (rd_ok) begin
        case (wb_adr_i)
          `PTWD_ADDR_CONFIG:
            wb_dat_o[7:0] <= wdog_config_reg[`PTWD_CFG_LCFG] ? `PTWD_FILL_DATA : wdog_config_reg;
          `PTWD_ADDR_PRESCALER:
            wb_dat_o[2:0] <= wdog_config_reg[`PTWD_CFG_LPRE] ? 3'h0 : slow_prescaler_reg;
          `PTWD_ADDR_PRESET:
            wb_dat_o[PRESET_W-1:0] <= wdog_config_reg[`PTWD_CFG_LPRESET]
              ? {PRESET_W{1'b0}} : periodic_preset_reg;
          `PTWD_ADDR_TCSR:
            wb_dat_o[2:0] <= wdog_config_reg[`PTWD_CFG_LPRESET] ? 3'h0
              : {timer_irq_enable, terminal_count_flag, restart_reg};
          `PTWD_ADDR_STATUS:
            wb_dat_o[8:0] <= {wdog_running_reg, wdog_count_reg};
          default: wb_dat_o <= 32'h00000000; // write-only and unmapped read zero
        endcase
      end
    end
  end
endmodule // ptwd_timer_wdog
`default_nettype wire

//--- ptwd_timer_wdog_properties.sv
// port checker for the periodic timer and watchdog
// assumes one clk domain, bound onto ptwd_timer_wdog
`timescale 1ns/1ps
`default_nettype none
`include "ptwd_defs.vh"
module ptwd_props (
  input wire clk,
  input wire resetn,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:2] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire timer_irq,
  input wire periodic_timer_output,
  input wire wdog_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire rd = wb_ack_o && !wb_we_i;
  ack_take_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_idle_a: assert property (!wb_cyc_i |=> !wb_ack_o) else $error("stray ack");
  wo_read_a: assert property (rd && wb_adr_i[5:3] == 3'h2 |-> wb_dat_o == 32'h0)
    else $error("write-only read nonzero");
  tcsr_rsvd_a: assert property (rd && wb_adr_i == `PTWD_ADDR_TCSR |-> wb_dat_o[31:3] == 29'h0)
    else $error("reserved bits set");
  irq_out_a: assert property (timer_irq |-> periodic_timer_output) else $error("irq alone");
  out_pulse_a: assert property (periodic_timer_output |=> !periodic_timer_output)
    else $error("output held");
  err_sticky_a: assert property (wdog_error |=> wdog_error) else $error("error dropped");
  cover property (timer_irq);
  cover property ($rose(wdog_error));
  cover property (rd && wb_adr_i == `PTWD_ADDR_TCSR && wb_dat_o[1]);
endmodule // ptwd_props
`default_nettype wire

//--- ptwd_timer_wdog_bench.sv
// self-checking bench for the periodic timer and watchdog
// assumes the design and its property checker compile first
`timescale 1ns/1ps
`default_nettype none
module ptwd_timer_wdog_bench;
  logic clk = 0, resetn = 0, slow = 0, cyc = 0, stb = 0, we = 0;
  logic [3:0] adr = 0;
  logic [31:0] dat = 0, q;
  wire [31:0] dato;
  wire ack, irq, pto, err;
  integer n_mismatch = 0, n_tests = 0, n_out = 0, n_irq = 0, ncyc = 0, seed = 90;
  integer p, n, t0, t1, i, a0, b0;
  ptwd_timer_wdog dut (.clk(clk), .resetn(resetn), .slow_clk(slow), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(dato), .wb_ack_o(ack), .timer_irq(irq), .periodic_timer_output(pto),
    .wdog_error(err));
  always #25 clk = ~clk;
  // 8-clk slow period stays inside the quarter-rate sync limit
  always begin
    repeat (4) @(posedge clk);
    slow <= ~slow;
  end
  always @(posedge clk) begin
    ncyc <= ncyc + 1;
    n_out <= n_out + (pto === 1'b1);
    n_irq <= n_irq + (irq === 1'b1);
  end
  function integer per(input integer pv, input integer c);
    per = (pv + 1) * (1 << c) * 8;
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task wb(input [3:0] a, input w, input [31:0] d);
    integer k;
    k = ncyc + 20;
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk); while (ack !== 1'b1 && ncyc < k);
    q = dato;
    if (ack !== 1'b1) n_mismatch++;
    {cyc, stb} <= 2'b00;
  endtask
  task wpulse(output integer t);
    integer k;
    k = ncyc + 5000;
    do @(posedge clk); while (pto !== 1'b1 && ncyc < k);
    t = ncyc;
    if (pto !== 1'b1) n_mismatch++;
  endtask
  task rst;
    resetn <= 0;
    repeat (5) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
  endtask
  task wsetup(input [31:0] cfg, input [31:0] r);
    rst;
    wb(4'h0, 1, cfg);
    wb(4'h4, 1, r);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #3000000;
    n_mismatch++;
    conclude;
  end
  initial begin
    rst;
    wb(4'h0, 0, 0);
    chk("config", 0, q);
    wb(4'h2, 0, 0);
    chk("preset", 32'hFFFF, q);
    wb(4'h3, 0, 0);
    chk("tcsr", 0, q);
    wb(4'h4, 0, 0);
    chk("reload", 0, q);
    for (i = 0; i < 6; i++) begin
      p = 1 + $unsigned($random(seed)) % 7;
      wb(4'h1, 1, i);
      wb(4'h2, 1, p);
      wb(4'h3, 1, 1);
      wpulse(t0);
      wpulse(t1);
      chk("period", per(p, i), t1 - t0);
      wb(4'h3, 0, 0);
      chk("tc set", 2, q & 3);
      wb(4'h3, 0, 0);
      chk("tc clear", 0, q & 2);
    end
    chk("irq off", 0, n_irq);
    a0 = n_irq;
    b0 = n_out;
    wpulse(t0);
    // zero in the restart position mid period must not stretch it
    wb(4'h3, 1, 4);
    wpulse(t1);
    chk("no restart", per(p, 5), t1 - t0);
    @(posedge clk);
    chk("irq on", 1, n_irq - a0);
    chk("pulses", 2, n_out - b0);
    $display("timer done");
    n = 5 + $unsigned($random(seed)) % 4;
    wsetup(32'h30, n);
    wb(4'h0, 1, 0);
    wb(4'h0, 0, 0);
    chk("sticky", 32'h30, q);
    wb(4'h0, 1, 32'h2F);
    // locked reload write of 1 would make the services below late
    wb(4'h4, 1, 1);
    wb(4'h0, 0, 0);
    chk("full lock", 0, q);
    for (i = 0; i < 4; i++) begin
      repeat (16) @(posedge clk);
      wb(4'h5, 1, 8'h5C);
      chk("serviced", 0, err);
    end
    repeat (8 * n - 16) @(posedge clk);
    chk("not late", 0, err);
    repeat (8 * n) @(posedge clk);
    chk("late", 1, err);
    wsetup(32'h31, 8);
    wb(4'h0, 0, 0);
    chk("locked", 0, q);
    t0 = $random(seed) & 255;
    if (t0 == 8'h5C) t0 = 0;
    wb(4'h5, 1, t0);
    repeat (4) @(posedge clk);
    chk("bad key", 1, err);
    wsetup(32'h30, 8);
    // three writes span under one tick whatever the phase
    repeat (3) wb(4'h5, 1, 8'h5C);
    repeat (4) @(posedge clk);
    chk("double", 1, err);
    rst;
    wb(4'h0, 1, 32'h10);
    repeat (3) wb(4'h5, 1, 8'h11);
    repeat (200) @(posedge clk);
    chk("ignored", 0, err);
    wb(4'h6, 0, 0);
    chk("stopped", 0, q[8]);
    $display("watchdog done");
    conclude;
  end
endmodule // ptwd_timer_wdog_bench
bind ptwd_timer_wdog ptwd_props u_props (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .timer_irq(timer_irq), .periodic_timer_output(periodic_timer_output),
  .wdog_error(wdog_error));
`default_nettype wire
